// [hdl/vic_pkg.sv]
// Constants and types shared by the interrupt controller files.
// Assumes a 32-bit word register bus with byte addresses.
package vic_pkg;
  localparam int VIC_NUM_SRC = 54;
  localparam int VIC_NUM_INT = 32;
  localparam int VIC_NUM_EXT = 3;
  localparam int VIC_NUM_EXP = 16;
  localparam int VIC_NUM_XTRA = 3;
  localparam int VIC_NUM_GP = 19;
  localparam int VIC_NUM_ALT = 10;
  localparam int VIC_NUM_SLOT = 32;
  localparam int VIC_EXT_BASE = 32;
  localparam int VIC_GP_BASE = 35;
  localparam int VIC_ADDR_W = 9;
  localparam int VIC_MODE_W = 3;

  localparam logic [8:0] VIC_OFF_PEND_LO = 9'h000;
  localparam logic [8:0] VIC_OFF_PEND_HI = 9'h004;
  localparam logic [8:0] VIC_OFF_EN_LO = 9'h008;
  localparam logic [8:0] VIC_OFF_EN_HI = 9'h00c;
  localparam logic [8:0] VIC_OFF_ROUTE_LO = 9'h010;
  localparam logic [8:0] VIC_OFF_ROUTE_HI = 9'h014;
  localparam logic [8:0] VIC_OFF_POL = 9'h018;
  localparam logic [8:0] VIC_OFF_FLVL_LO = 9'h01c;
  localparam logic [8:0] VIC_OFF_FLVL_HI = 9'h020;
  localparam logic [8:0] VIC_OFF_NMASK = 9'h024;
  localparam logic [8:0] VIC_OFF_FMASK = 9'h028;
  localparam logic [8:0] VIC_OFF_VECTOR = 9'h02c;
  localparam logic [8:0] VIC_OFF_PIN_DIR = 9'h034;
  localparam logic [8:0] VIC_OFF_PIN_OUT = 9'h038;
  localparam logic [8:0] VIC_OFF_PIN_IN = 9'h03c;
  localparam logic [8:0] VIC_OFF_PIN_IRQ = 9'h040;
  localparam logic [8:0] VIC_OFF_MODE0 = 9'h044;
  localparam logic [8:0] VIC_OFF_MODE1 = 9'h048;
  localparam logic [8:0] VIC_OFF_EDGE_CLR = 9'h04c;
  localparam logic [8:0] VIC_OFF_EVT_STAT = 9'h050;
  localparam logic [8:0] VIC_OFF_EVT_CLR = 9'h054;
  localparam logic [8:0] VIC_OFF_EVT_EN = 9'h058;
  // Slot table: base plus four times the slot number
  localparam logic [8:0] VIC_OFF_SLOT_BASE = 9'h100;

  localparam logic [5:0] VIC_NMASK_RST = 6'h3f;
  localparam logic [1:0] VIC_FMASK_RST = 2'h3;
  localparam logic [5:0] VIC_PRIO_NONE = 6'h20;

  typedef enum logic [2:0] {
    VIC_DET_HIGH,
    VIC_DET_LOW,
    VIC_DET_RISE,
    VIC_DET_FALL,
    VIC_DET_BOTH
  } vic_det_t;
endpackage

// [hdl/vic_pin_detect.sv]
// Per-pin interrupt detector for the general purpose port pins.
// Assumes pin levels already synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module vic_pin_detect import vic_pkg::*; #(
  parameter int N = 19
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [N-1:0] pinIn,
  input wire logic [N*VIC_MODE_W-1:0] modeIn,
  input wire logic [N-1:0] armIn,
  input wire logic [N-1:0] clearIn,
  output logic [N-1:0] pendOut
);
  typedef struct packed {
    logic [N-1:0] prev;
    logic [N-1:0] pend;
  } vic_det_st_t;

  vic_det_st_t s_q, s_d;
  logic rise, fall;

  always_comb begin
    s_d = s_q;
    rise = 1'b0;
    fall = 1'b0;
    s_d.prev = pinIn;
    for (int i = 0; i < N; i++) begin
      rise = pinIn[i] & ~s_q.prev[i];
      fall = ~pinIn[i] & s_q.prev[i];
      if (!armIn[i]) begin
        s_d.pend[i] = 1'b0;
      end else begin
        case (vic_det_t'(modeIn[i*VIC_MODE_W +: VIC_MODE_W]))
          VIC_DET_HIGH: s_d.pend[i] = pinIn[i];
          VIC_DET_LOW: s_d.pend[i] = ~pinIn[i];
          // Edge set wins over a clear in the same cycle
          VIC_DET_RISE: s_d.pend[i] = rise | (s_q.pend[i] & ~clearIn[i]);
          VIC_DET_FALL: s_d.pend[i] = fall | (s_q.pend[i] & ~clearIn[i]);
          VIC_DET_BOTH: s_d.pend[i] = rise | fall | (s_q.pend[i] & ~clearIn[i]);
          default: s_d.pend[i] = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pendOut = s_q.pend;

  AST_EDGE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    armIn[0] && s_q.pend[0] && !clearIn[0] && $stable(armIn[0]) &&
    modeIn[2:0] == 3'h2 && $stable(modeIn[2:0]) |=> s_q.pend[0])
    else $error("latched edge lost without clear");
  AST_RISE_SET: assert property (@(posedge clk) disable iff (!rst_n)
    armIn[0] && modeIn[2:0] == 3'h2 && pinIn[0] && !s_q.prev[0]
    |=> s_q.pend[0])
    else $error("rising edge not latched");
endmodule // vic_pin_detect
`default_nettype wire

// [hdl/vic_controller.sv]
// Vectored interrupt controller with Avalon-MM register slave.
// Assumes all source and pin inputs are synchronous to clk.
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module vic_controller import vic_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [VIC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [VIC_NUM_INT-1:0] intSrcIn,
  input wire logic [VIC_NUM_EXT-1:0] extIntIn,
  input wire logic [VIC_NUM_EXP-1:0] expandedPortPinsIn,
  output logic [VIC_NUM_EXP-1:0] expandedPortPinsOut,
  output logic [VIC_NUM_EXP-1:0] expandedPortPinsOe,
  input wire logic [VIC_NUM_XTRA-1:0] extraPortPinsIn,
  output logic [VIC_NUM_XTRA-1:0] extraPortPinsOut,
  output logic [VIC_NUM_XTRA-1:0] extraPortPinsOe,
  input wire logic [3:0] alternatePortHPinsIn,
  input wire logic alternatePortCPinIn,
  input wire logic [4:0] altMiscPinsIn,
  output logic irqNormal,
  output logic fastInterruptRequest,
  output logic ctlIrq
);
  typedef struct packed {
    logic [VIC_NUM_SRC-1:0] en;
    logic [VIC_NUM_SRC-1:0] route;
    logic [VIC_NUM_INT-1:0] pol;
    logic [VIC_NUM_SRC-1:0] fastLvl;
    logic [5:0] nThr;
    logic [1:0] fMask;
    logic [VIC_NUM_SLOT-1:0][6:0] slot;
    logic [VIC_NUM_GP-1:0] dir;
    logic [VIC_NUM_GP-1:0] pinOut;
    logic [VIC_NUM_GP-1:0] irqEn;
    logic [VIC_NUM_GP*VIC_MODE_W-1:0] mode;
    logic [VIC_NUM_GP-1:0] edgeClr;
    logic [1:0] evt;
    logic [1:0] evtEn;
    logic irqN;
    logic irqF;
    logic ctl;
    logic waitReq;
    logic [31:0] rdata;
  } vic_st_t;

  vic_st_t s_q, s_d;
  logic [VIC_NUM_GP-1:0] gpPend;
  logic [VIC_NUM_GP-1:0] gpIn;
  logic [VIC_NUM_SRC-1:0] pend, normCand, fastCand, fastHi, fastLo;
  logic [VIC_NUM_SRC-1:0][5:0] prio;
  logic [5:0] normId, normPrio, fastId;
  logic normAny, fastAny, wrAcc;
  logic [31:0] rd;

  // Lowest numbered set bit; the lowest source wins on a tie
  function automatic logic [5:0] firstIdx(input logic [VIC_NUM_SRC-1:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = VIC_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] lo32(input logic [VIC_NUM_SRC-1:0] v);
    return v[31:0];
  endfunction

  function automatic logic [31:0] hi32(input logic [VIC_NUM_SRC-1:0] v);
    return {10'h000, v[VIC_NUM_SRC-1:32]};
  endfunction

  assign gpIn = {extraPortPinsIn, expandedPortPinsIn};

  // Only the 19 port pins feed the detector; alternate pins have no path
  vic_pin_detect #(
    .N(VIC_NUM_GP)
  ) u_detect (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(gpIn),
    .modeIn(s_q.mode),
    .armIn(s_q.irqEn & ~s_q.dir),
    .clearIn(s_q.edgeClr),
    .pendOut(gpPend)
  );

  always_comb begin
    s_d = s_q;
    pend = {gpPend, extIntIn, intSrcIn ^ s_q.pol};
    // Unslotted sources rank below every slot
    prio = '0;
    for (int i = 0; i < VIC_NUM_SRC; i++) begin
      prio[i] = VIC_PRIO_NONE;
    end
    for (int k = VIC_NUM_SLOT - 1; k >= 0; k--) begin
      if (s_q.slot[k][6] && s_q.slot[k][5:0] < 6'(VIC_NUM_SRC)) begin
        prio[s_q.slot[k][5:0]] = 6'(k);
      end
    end
    normCand = '0;
    for (int i = 0; i < VIC_NUM_SRC; i++) begin
      normCand[i] = pend[i] & s_q.en[i] & ~s_q.route[i]
        & (prio[i] < s_q.nThr);
    end
    fastCand = pend & s_q.en & s_q.route;
    fastHi = fastCand & s_q.fastLvl & {VIC_NUM_SRC{s_q.fMask[1]}};
    fastLo = fastCand & ~s_q.fastLvl & {VIC_NUM_SRC{s_q.fMask[0]}};
    normId = 6'h00;
    normPrio = 6'h3f;
    for (int i = 0; i < VIC_NUM_SRC; i++) begin
      if (normCand[i] && prio[i] < normPrio) begin
        normPrio = prio[i];
        normId = 6'(i);
      end
    end
    normAny = |normCand;
    // High fast level beats low while fMask[1] leaves high unmasked
    fastAny = |(fastHi | fastLo);
    fastId = (|fastHi) ? firstIdx(fastHi) : firstIdx(fastLo);

    s_d.irqN = normAny;
    s_d.irqF = fastAny;
    s_d.edgeClr = '0;

    // Status events: new request starts; set wins over clear
    wrAcc = avs_write & ~s_q.waitReq;
    if (wrAcc && avs_address == VIC_OFF_EVT_CLR) begin
      s_d.evt = s_q.evt & ~avs_writedata[1:0];
    end
    if (normAny && !s_q.irqN) begin
      s_d.evt[0] = 1'b1;
    end
    if (fastAny && !s_q.irqF) begin
      s_d.evt[1] = 1'b1;
    end
    s_d.ctl = |(s_d.evt & s_q.evtEn);

    // One wait cycle per access; data is ready when waitrequest drops
    rd = 32'h0000_0000;
    // Slot table spans 0x100..0x17c only; no aliasing above it
    if (avs_address[8:7] == 2'b10) begin
      rd = {25'h0000000, s_q.slot[avs_address[6:2]]};
    end else begin
      case (avs_address)
        VIC_OFF_PEND_LO: rd = lo32(pend);
        VIC_OFF_PEND_HI: rd = hi32(pend);
        VIC_OFF_EN_LO: rd = lo32(s_q.en);
        VIC_OFF_EN_HI: rd = hi32(s_q.en);
        VIC_OFF_ROUTE_LO: rd = lo32(s_q.route);
        VIC_OFF_ROUTE_HI: rd = hi32(s_q.route);
        VIC_OFF_POL: rd = s_q.pol;
        VIC_OFF_FLVL_LO: rd = lo32(s_q.fastLvl);
        VIC_OFF_FLVL_HI: rd = hi32(s_q.fastLvl);
        VIC_OFF_NMASK: rd = {26'h0000000, s_q.nThr};
        VIC_OFF_FMASK: rd = {30'h00000000, s_q.fMask};
        VIC_OFF_VECTOR: rd = {12'h000, fastAny, fastId, normAny,
          normPrio[4:0], normAny & normPrio[5], normId};
        VIC_OFF_PIN_DIR: rd = {13'h0000, s_q.dir};
        VIC_OFF_PIN_OUT: rd = {13'h0000, s_q.pinOut};
        VIC_OFF_PIN_IN: rd = {3'h0, altMiscPinsIn, alternatePortCPinIn,
          alternatePortHPinsIn, gpIn};
        VIC_OFF_PIN_IRQ: rd = {13'h0000, s_q.irqEn};
        VIC_OFF_MODE0: rd = {2'h0, s_q.mode[29:0]};
        VIC_OFF_MODE1: rd = {5'h00, s_q.mode[56:30]};
        VIC_OFF_EVT_STAT: rd = {30'h00000000, s_q.evt};
        VIC_OFF_EVT_EN: rd = {30'h00000000, s_q.evtEn};
        default: rd = 32'h0000_0000;
      endcase
    end

    if ((avs_read || avs_write) && s_q.waitReq) begin
      s_d.waitReq = 1'b0;
      if (avs_read) begin
        s_d.rdata = rd;
      end
    end else begin
      s_d.waitReq = 1'b1;
    end

    if (wrAcc) begin
      if (avs_address[8:7] == 2'b10) begin
        s_d.slot[avs_address[6:2]] = avs_writedata[6:0];
      end else begin
        case (avs_address)
          VIC_OFF_EN_LO: s_d.en[31:0] = avs_writedata;
          VIC_OFF_EN_HI: s_d.en[53:32] = avs_writedata[21:0];
          VIC_OFF_ROUTE_LO: s_d.route[31:0] = avs_writedata;
          VIC_OFF_ROUTE_HI: s_d.route[53:32] = avs_writedata[21:0];
          VIC_OFF_POL: s_d.pol = avs_writedata;
          VIC_OFF_FLVL_LO: s_d.fastLvl[31:0] = avs_writedata;
          VIC_OFF_FLVL_HI: s_d.fastLvl[53:32] = avs_writedata[21:0];
          VIC_OFF_NMASK: s_d.nThr = avs_writedata[5:0];
          VIC_OFF_FMASK: s_d.fMask = avs_writedata[1:0];
          VIC_OFF_PIN_DIR: s_d.dir = avs_writedata[18:0];
          VIC_OFF_PIN_OUT: s_d.pinOut = avs_writedata[18:0];
          VIC_OFF_PIN_IRQ: s_d.irqEn = avs_writedata[18:0];
          VIC_OFF_MODE0: s_d.mode[29:0] = avs_writedata[29:0];
          VIC_OFF_MODE1: s_d.mode[56:30] = avs_writedata[26:0];
          VIC_OFF_EDGE_CLR: s_d.edgeClr = avs_writedata[18:0];
          VIC_OFF_EVT_EN: s_d.evtEn = avs_writedata[1:0];
          default: s_d.evtEn = s_q.evtEn;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.nThr <= VIC_NMASK_RST;
      s_q.fMask <= VIC_FMASK_RST;
      s_q.waitReq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitReq;
  assign expandedPortPinsOut = s_q.pinOut[15:0];
  assign expandedPortPinsOe = s_q.dir[15:0];
  assign extraPortPinsOut = s_q.pinOut[18:16];
  assign extraPortPinsOe = s_q.dir[18:16];
  assign irqNormal = s_q.irqN;
  assign fastInterruptRequest = s_q.irqF;
  assign ctlIrq = s_q.ctl;

  AST_NORM_ON: assert property (@(posedge clk) disable iff (!rst_n)
    normAny |=> irqNormal)
    else $error("normal request missing");
  AST_NORM_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    !normAny |=> !irqNormal)
    else $error("normal request without unmasked source");
  AST_FAST_ON: assert property (@(posedge clk) disable iff (!rst_n)
    fastAny |=> fastInterruptRequest)
    else $error("fast request missing");
  AST_ROUTE_EXCL: assert property (@(posedge clk) disable iff (!rst_n)
    (normCand & fastCand) == '0)
    else $error("source on both outputs");
  AST_THRESH: assert property (@(posedge clk) disable iff (!rst_n)
    normAny |-> normPrio < s_q.nThr && normCand[normId])
    else $error("masked priority selected");
  AST_FAST_LVL: assert property (@(posedge clk) disable iff (!rst_n)
    (|fastHi) |-> s_q.fastLvl[fastId] && s_q.fMask[1])
    else $error("low fast level beat high level");
  AST_EXT_LVL: assert property (@(posedge clk) disable iff (!rst_n)
    pend[VIC_EXT_BASE +: VIC_NUM_EXT] == extIntIn)
    else $error("external line not active high");
  AST_POLARITY: assert property (@(posedge clk) disable iff (!rst_n)
    pend[0] == (intSrcIn[0] ^ s_q.pol[0]))
    else $error("internal polarity wrong");
  AST_ALT_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(pend[VIC_NUM_SRC-1:VIC_GP_BASE]) && $stable(s_q) |=>
    $stable(gpPend) || $changed($past(gpIn)) || $changed(gpIn))
    else $error("port pending moved without port pin change");
  AST_WAIT_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1
    avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  AST_EVT_SET: assert property (@(posedge clk) disable iff (!rst_n)
    normAny && !irqNormal |=> s_q.evt[0])
    else $error("normal start event lost");
endmodule // vic_controller
`default_nettype wire

// [sim/vic_core_model.sv]
// Behavioural model of the core's two interrupt request inputs.
// Assumes request lines are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module vic_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irqNormal,
  input wire logic fastInterruptRequest,
  output var logic normalSeen,
  output var logic fastSeen
);
  // Core registers its request inputs once per edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      normalSeen <= 1'b0;
      fastSeen <= 1'b0;
    end else begin
      normalSeen <= irqNormal;
      fastSeen <= fastInterruptRequest;
    end
  end
endmodule // vic_core_model
`default_nettype wire

// [sim/vic_controller_bench.sv]
// Self-checking bench for the interrupt controller.
// Assumes vic_pkg and the core model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module vic_controller_bench import vic_pkg::*; ;
  typedef struct packed {logic [31:0] val; logic [31:0] msk;} vic_note_t;
  logic clk, rst_n, rd, wr, wreq, irqN, irqF, ctl, coreN, coreF, cPin;
  logic [8:0] adr;
  logic [31:0] wdat, rdat, src, seed;
  logic [2:0] ext, xtrDrv, xtrOut, xtrOe;
  logic [15:0] expDrv, expOut, expOe;
  logic [3:0] hPins;
  logic [4:0] misc;
  int err_count, n_tests, cyc;
  vic_note_t notes[$];
  // Pins driven by the controller win over the bench
  wire logic [15:0] expWire = (expOe & expOut) | (~expOe & expDrv);
  wire logic [2:0] xtrWire = (xtrOe & xtrOut) | (~xtrOe & xtrDrv);

  vic_controller u_vic_controller (.clk(clk), .rst_n(rst_n),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .intSrcIn(src),
    .extIntIn(ext), .expandedPortPinsIn(expWire),
    .expandedPortPinsOut(expOut), .expandedPortPinsOe(expOe),
    .extraPortPinsIn(xtrWire), .extraPortPinsOut(xtrOut),
    .extraPortPinsOe(xtrOe), .alternatePortHPinsIn(hPins),
    .alternatePortCPinIn(cPin), .altMiscPinsIn(misc), .irqNormal(irqN),
    .fastInterruptRequest(irqF), .ctlIrq(ctl));
  vic_core_model u_vic_core_model (.clk(clk), .rst_n(rst_n),
    .irqNormal(irqN), .fastInterruptRequest(irqF), .normalSeen(coreN),
    .fastSeen(coreF));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pin(input string what, input logic seen, exp);
    check(what, {31'h0, seen}, {31'h0, exp});
  endtask

  // Idle edge after release avoids re-raising in the same step
  task automatic bus(input logic [8:0] a, input logic [31:0] d, input logic w);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wrt(input logic [8:0] a, input logic [31:0] d);
    bus(a, d, 1'b1);
  endtask

  task automatic rdx(input logic [8:0] a, input logic [31:0] e, m);
    notes.push_back('{e & m, m});
    bus(a, 32'h0, 1'b0);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Read answers are compared against the oldest note
  always @(posedge clk) begin
    if (rd && wreq === 1'b0 && notes.size() > 0) begin
      vic_note_t n;
      n = notes.pop_front();
      check($sformatf("reg %h", adr), rdat & n.msk, n.val);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      results();
    end
  end

  initial begin
    int id;
    logic [31:0] p, s, act;
    {rst_n, rd, wr, adr, wdat, src, ext, expDrv, xtrDrv} = '0;
    {hPins, cPin, misc} = '0;
    seed = 32'h9975bed0;
    wt(3);
    pin("waitreq", wreq, 1'b1);
    rst_n <= 1'b1;
    @(posedge clk);
    rdx(VIC_OFF_NMASK, 32'h3f, '1);
    rdx(VIC_OFF_FMASK, 32'h3, '1);
    rdx(VIC_OFF_EN_LO, 32'h0, '1);
    wrt(9'h1fc, '1);
    rdx(9'h1fc, 32'h0, '1);
    $display("test reset done");
    wrt(VIC_OFF_EN_LO, '1);
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      p = seed;
      seed = lfsr(seed);
      s = (k == 7) ? p : seed;
      wrt(VIC_OFF_POL, p);
      src <= s;
      wt(3);
      act = s ^ p;
      id = 0;
      for (int i = 31; i >= 0; i--) if (act[i]) id = i;
      pin("irqNormal", coreN, |act);
      rdx(VIC_OFF_VECTOR, {19'h0, |act, 5'h0, 1'b1, 6'(id)},
          act != 0 ? 32'h107f : 32'h1000);
    end
    src <= '0;
    wrt(VIC_OFF_POL, 32'h0);
    $display("test level sources done");
    wrt(VIC_OFF_SLOT_BASE, 32'h45);
    wrt(VIC_OFF_SLOT_BASE + 9'h4, 32'h54);
    src <= 32'h100022;
    wt(3);
    rdx(VIC_OFF_VECTOR, 32'h1005, 32'h1fff);
    wrt(VIC_OFF_NMASK, 32'h1);
    src <= 32'h100002;
    wt(3);
    pin("irqNormal", coreN, 1'b0);
    wrt(VIC_OFF_NMASK, 32'h2);
    wt(3);
    pin("irqNormal", coreN, 1'b1);
    rdx(VIC_OFF_VECTOR, 32'h1094, 32'h1fff);
    wrt(VIC_OFF_NMASK, 32'h3f);
    $display("test slots done");
    wrt(VIC_OFF_ROUTE_LO, 32'hc);
    wrt(VIC_OFF_FLVL_LO, 32'h8);
    src <= 32'hc;
    wt(3);
    pin("fast", coreF, 1'b1);
    pin("irqNormal", coreN, 1'b0);
    rdx(VIC_OFF_VECTOR, 32'h86000, 32'hfe000);
    wrt(VIC_OFF_FMASK, 32'h1);
    wt(3);
    rdx(VIC_OFF_VECTOR, 32'h84000, 32'hfe000);
    wrt(VIC_OFF_FMASK, 32'h0);
    wt(3);
    pin("fast", coreF, 1'b0);
    wrt(VIC_OFF_FMASK, 32'h3);
    src <= '0;
    wrt(VIC_OFF_ROUTE_LO, 32'h0);
    $display("test fast done");
    rdx(VIC_OFF_EVT_STAT, 32'h3, 32'h3);
    wrt(VIC_OFF_EVT_CLR, 32'h3);
    rdx(VIC_OFF_EVT_STAT, 32'h0, 32'h3);
    wrt(VIC_OFF_EVT_EN, 32'h1);
    wrt(VIC_OFF_EN_HI, 32'h2);
    ext <= 3'b101;
    wt(3);
    pin("irqNormal", coreN, 1'b0);
    ext <= 3'b010;
    wt(3);
    pin("irqNormal", coreN, 1'b1);
    pin("ctlIrq", ctl, 1'b1);
    rdx(VIC_OFF_VECTOR, 32'h1061, 32'h107f);
    wrt(VIC_OFF_EVT_EN, 32'h0);
    wt(1);
    pin("ctlIrq", ctl, 1'b0);
    ext <= 3'b000;
    wrt(VIC_OFF_EVT_CLR, 32'h1);
    wrt(VIC_OFF_EVT_EN, 32'h1);
    pin("ctlIrq", ctl, 1'b0);
    $display("test events done");
    wrt(VIC_OFF_EN_HI, 32'h8);
    wrt(VIC_OFF_PIN_IRQ, 32'h1);
    for (int m = 0; m < 5; m++) begin
      wrt(VIC_OFF_MODE0, 32'(m));
      wrt(VIC_OFF_EDGE_CLR, 32'h1);
      wt(3);
      pin("pin idle", coreN, m == 1);
      expDrv[0] <= 1'b1;
      wt(4);
      pin("pin high", coreN, m == 0 || m == 2 || m == 4);
      expDrv[0] <= 1'b0;
      wt(4);
      pin("pin low", coreN, m != 0);
    end
    wrt(VIC_OFF_MODE0, 32'h0);
    wrt(VIC_OFF_PIN_OUT, 32'h1);
    wrt(VIC_OFF_PIN_DIR, 32'h1);
    wt(3);
    pin("pin oe", expOe[0], 1'b1);
    pin("pin output", coreN, 1'b0);
    rdx(VIC_OFF_PIN_IN, 32'h1, 32'h1);
    wrt(VIC_OFF_PIN_DIR, 32'h0);
    wrt(VIC_OFF_MODE0, 32'h5);
    expDrv[0] <= 1'b1;
    wt(4);
    pin("pin off", coreN, 1'b0);
    expDrv[0] <= 1'b0;
    wrt(VIC_OFF_EN_HI, 32'h80000);
    wrt(VIC_OFF_PIN_IRQ, 32'h10000);
    xtrDrv <= 3'b001;
    wt(4);
    pin("extra pin", coreN, 1'b1);
    xtrDrv <= 3'b000;
    $display("test port pins done");
    wrt(VIC_OFF_EN_HI, '1);
    wrt(VIC_OFF_PIN_IRQ, 32'h7ffff);
    wrt(VIC_OFF_MODE0, 32'h0);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      {hPins, cPin, misc} <= seed[9:0];
      wt(3);
      pin("alt pins", coreN, 1'b0);
      rdx(VIC_OFF_PIN_IN, {3'h0, seed[4:0], seed[5], seed[9:6], 19'h0},
          32'h1ff80000);
    end
    $display("test alternate pins done");
    results();
  end
endmodule // vic_controller_bench
`default_nettype wire
